/* spcr_pkg.sv */
/*
 * Shared definitions of the serial-port configuration register bank.
 * Assumes a single 50 MHz system clock domain.
 */
package spcr_pkg;
   localparam int unsigned ADDR_W = 14;
   localparam int unsigned DATA_W = 8;
   localparam logic [13:0] OFS_LINK_PRIMARY = 14'h0000;
   localparam logic [13:0] OFS_LINK_SECONDARY = 14'h0001;
   localparam logic [13:0] OFS_DEVICE_RESERVED = 14'h0002;
   localparam logic [7:0] RST_LINK_PRIMARY = 8'h10;
   localparam logic [7:0] RST_LINK_SECONDARY = 8'h80;
   localparam logic [7:0] RST_DEVICE_RESERVED = 8'h00;
   localparam int unsigned BIT_SOFT_RESET_HI = 7;
   localparam int unsigned BIT_ADDR_STEP_DIR = 5;
   localparam int unsigned BIT_SERIAL_OUT_ON = 4;
   localparam int unsigned BIT_SOFT_RESET_LO = 0;
   localparam int unsigned BIT_ONE_CMD_FRAME = 7;
   localparam int unsigned BIT_COMPACT_ADDR = 3;
   // Bits of each register that a host write may change.
   localparam logic [7:0] WMASK_LINK_PRIMARY = 8'ha1;
   localparam logic [7:0] WMASK_LINK_SECONDARY = 8'h08;
   localparam logic [13:0] ADDR_STEP = 14'h0001;
   localparam logic [4:0] ADDR_BITS_LONG = 5'h0e;
   localparam logic [4:0] ADDR_BITS_SHORT = 5'h06;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [13:0] addr;
      logic [7:0] wdata;
   } spcr_access_t;

   typedef struct packed {
      logic addr_step_up;
      logic compact_addr;
      logic serial_out_on;
      logic one_command;
      logic [4:0] addr_bits;
   } spcr_setup_t;
endpackage : spcr_pkg

/* spcr_field.sv */
/*
 * One 8-bit register with per-bit write mask and reset value.
 * Assumes writes come from the serial front end in the system clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module spcr_field #(
   parameter logic [7:0] RST_VAL = 8'h00,
   parameter logic [7:0] WMASK = 8'h00
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   // Control
   input wire logic soft_rst_i,
   input wire logic we_i,
   input wire logic [7:0] wdata_i,
   // State
   output logic [7:0] q_o
);
   logic [7:0] next_q;

   always_comb
   begin
      next_q = q_o;
      if (soft_rst_i)
      begin
         next_q = RST_VAL;
      end
      else if (we_i)
      begin
         next_q = (q_o & ~WMASK) | (wdata_i & WMASK);
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         q_o <= RST_VAL;
      end
      else if (ce_i)
      begin
         q_o <= next_q;
      end
   end
endmodule : spcr_field
`default_nettype wire

/* spcr_regs.sv */
/*
 * Serial-port configuration register bank: primary and secondary link
 * setup registers plus a reserved register, with two-bit soft reset and
 * multibyte address stepping. Assumes the serial front end delivers one
 * decoded byte access per cycle, synchronous to clk_sys_i.
 */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - A soft reset fires only when one write sets both reset bits.
// - A soft reset restores every other register to its default.
// - The soft reset clears both reset bits afterwards.
// - With step direction 0 the address falls by one per data byte.
// - With step direction 1 the address rises by one per data byte.
// - The single-command bit always reads as a fixed 1.
// - The compact-address bit picks a 6-bit or else a 14-bit address.
// - The reserved register at offset 2 is read-only and reads zero.
module spcr_regs (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   // Byte access from the serial front end
   input wire spcr_pkg::spcr_access_t acc_i,
   input wire logic frame_start_i,
   // Read data and address walk
   output logic [7:0] rdata_o,
   output logic [13:0] cur_addr_o,
   // Settings for the serial front end
   output spcr_pkg::spcr_setup_t setup_o,
   output logic soft_reset_o
);
   logic [7:0] primary;
   logic [7:0] secondary;
   logic [7:0] next_rdata;
   logic [13:0] next_cur_addr;
   logic wr_primary;
   logic wr_secondary;
   logic reset_req;
   logic reset_pend;
   logic next_reset_pend;
   logic rd_primary;
   logic rd_secondary;
   logic rd_reserved;

   always_comb
   begin
      wr_primary = 1'b0;
      wr_secondary = 1'b0;
      if (acc_i.wr && acc_i.addr == spcr_pkg::OFS_LINK_PRIMARY)
      begin
         wr_primary = 1'b1;
      end
      else if (acc_i.wr && acc_i.addr == spcr_pkg::OFS_LINK_SECONDARY)
      begin
         wr_secondary = 1'b1;
      end
   end

   // Read decode is kept apart from the write decode, since one byte access
   // may carry both strobes.
   always_comb
   begin
      rd_primary = 1'b0;
      rd_secondary = 1'b0;
      rd_reserved = 1'b0;
      if (acc_i.addr == spcr_pkg::OFS_LINK_PRIMARY)
      begin
         rd_primary = acc_i.rd;
      end
      else if (acc_i.addr == spcr_pkg::OFS_LINK_SECONDARY)
      begin
         rd_secondary = acc_i.rd;
      end
      else if (acc_i.addr == spcr_pkg::OFS_DEVICE_RESERVED)
      begin
         rd_reserved = acc_i.rd;
      end
   end

   // Both halves must be set in the same byte; one alone does nothing.
   assign reset_req = wr_primary
      && acc_i.wdata[spcr_pkg::BIT_SOFT_RESET_HI]
      && acc_i.wdata[spcr_pkg::BIT_SOFT_RESET_LO];

   // The reset is carried out one cycle after the write so the host sees
   // the bits set for at most one cycle and never after.
   always_comb
   begin
      next_reset_pend = reset_req;
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         reset_pend <= 1'b0;
      end
      else if (ce_i)
      begin
         reset_pend <= next_reset_pend;
      end
   end

   assign soft_reset_o = reset_pend;

   // Primary keeps its contents across a soft reset except the two bits.
   // A host write in the pending cycle still lands in its other bits.
   logic [7:0] primary_wdata;
   logic primary_we;
   always_comb
   begin
      primary_we = wr_primary | reset_pend;
      primary_wdata = acc_i.wdata;
      if (reset_pend)
      begin
         primary_wdata = primary;
         if (wr_primary)
         begin
            primary_wdata = acc_i.wdata;
         end
         primary_wdata[spcr_pkg::BIT_SOFT_RESET_HI] = 1'b0;
         primary_wdata[spcr_pkg::BIT_SOFT_RESET_LO] = 1'b0;
      end
   end

   spcr_field #(
      .RST_VAL(spcr_pkg::RST_LINK_PRIMARY),
      .WMASK(spcr_pkg::WMASK_LINK_PRIMARY)
   ) u_primary (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .ce_i(ce_i),
      .soft_rst_i(1'b0),
      .we_i(primary_we),
      .wdata_i(primary_wdata),
      .q_o(primary)
   );

   spcr_field #(
      .RST_VAL(spcr_pkg::RST_LINK_SECONDARY),
      .WMASK(spcr_pkg::WMASK_LINK_SECONDARY)
   ) u_secondary (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .ce_i(ce_i),
      .soft_rst_i(reset_pend),
      .we_i(wr_secondary),
      .wdata_i(acc_i.wdata),
      .q_o(secondary)
   );

   always_comb
   begin
      setup_o.addr_step_up = primary[spcr_pkg::BIT_ADDR_STEP_DIR];
      setup_o.serial_out_on = primary[spcr_pkg::BIT_SERIAL_OUT_ON];
      setup_o.one_command = secondary[spcr_pkg::BIT_ONE_CMD_FRAME];
      setup_o.compact_addr = secondary[spcr_pkg::BIT_COMPACT_ADDR];
      if (secondary[spcr_pkg::BIT_COMPACT_ADDR])
      begin
         setup_o.addr_bits = spcr_pkg::ADDR_BITS_SHORT;
      end
      else
      begin
         setup_o.addr_bits = spcr_pkg::ADDR_BITS_LONG;
      end
   end

   // Read path; unmapped offsets read zero.
   always_comb
   begin
      next_rdata = rdata_o;
      if (rd_primary)
      begin
         next_rdata = primary;
      end
      else if (rd_secondary)
      begin
         next_rdata = secondary;
      end
      else if (rd_reserved)
      begin
         next_rdata = spcr_pkg::RST_DEVICE_RESERVED;
      end
      else if (acc_i.rd)
      begin
         next_rdata = 8'h00;
      end
   end

   // Address walk for multibyte accesses: loaded at frame start, then
   // stepped after each data byte in the selected direction.
   always_comb
   begin
      next_cur_addr = cur_addr_o;
      if (frame_start_i)
      begin
         next_cur_addr = acc_i.addr;
      end
      else if (acc_i.rd || acc_i.wr)
      begin
         if (setup_o.addr_step_up)
         begin
            next_cur_addr = acc_i.addr + spcr_pkg::ADDR_STEP;
         end
         else
         begin
            next_cur_addr = acc_i.addr - spcr_pkg::ADDR_STEP;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rdata_o <= 8'h00;
         cur_addr_o <= 14'h0000;
      end
      else if (ce_i)
      begin
         rdata_o <= next_rdata;
         cur_addr_o <= next_cur_addr;
      end
   end
endmodule : spcr_regs
`default_nettype wire

/* spcr_sva.sv */
/* Checker for the serial-port configuration register bank.
   Assumes one clock domain and the port set of spcr_regs. */
`timescale 1ns/1ps
`default_nettype none
module spcr_sva (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   // Watched ports
   input wire spcr_pkg::spcr_access_t acc_i,
   input wire logic frame_start_i,
   input wire logic [7:0] rdata_o,
   input wire logic [13:0] cur_addr_o,
   input wire spcr_pkg::spcr_setup_t setup_o,
   input wire logic soft_reset_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   logic go;
   logic fire;
   assign go = ce_i && (acc_i.wr || acc_i.rd);
   assign fire = ce_i && acc_i.wr && acc_i.addr == 14'h0000 &&
      acc_i.wdata[7] && acc_i.wdata[0];
   AST_SR_FIRE: assert property (
      fire |=> soft_reset_o) else $error("soft reset missing");
   AST_SR_ONE: assert property (
      soft_reset_o && ce_i && !fire |=> !soft_reset_o)
      else $error("soft reset stuck");
   AST_SR_CLEAR: assert property (
      (soft_reset_o && ce_i) ##1 (ce_i && acc_i.rd &&
      acc_i.addr == spcr_pkg::OFS_LINK_PRIMARY) |=>
      !rdata_o[7] && !rdata_o[0]) else $error("reset bits kept");
   AST_SEC_DEF: assert property (
      soft_reset_o && ce_i |=> !setup_o.compact_addr)
      else $error("no default");
   AST_STEP_DN: assert property (
      go && !frame_start_i && !setup_o.addr_step_up |=>
      cur_addr_o == $past(acc_i.addr) - spcr_pkg::ADDR_STEP)
      else $error("walk down wrong");
   AST_STEP_UP: assert property (
      go && !frame_start_i && setup_o.addr_step_up |=>
      cur_addr_o == $past(acc_i.addr) + spcr_pkg::ADDR_STEP)
      else $error("walk up wrong");
   AST_FRAME_LOAD: assert property (
      ce_i && frame_start_i |=> cur_addr_o == $past(acc_i.addr))
      else $error("walk not loaded");
   AST_FIXED: assert property (
      setup_o.one_command && setup_o.serial_out_on) else $error("fixed bit");
   AST_ADDR_LEN: assert property (
      setup_o.addr_bits == (setup_o.compact_addr ? 5'h06 : 5'h0e))
      else $error("address length wrong");
   AST_RSVD: assert property (
      ce_i && acc_i.rd && acc_i.addr == 14'h0002 |=> rdata_o == 8'h00)
      else $error("reserved not zero");
   cover property (fire);
   cover property (go && setup_o.addr_step_up);
   cover property (acc_i.wr && acc_i.addr == 14'h0002);
   cover property (ce_i && frame_start_i && acc_i.rd);
endmodule : spcr_sva
bind spcr_regs spcr_sva u_sva (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
   .ce_i(ce_i), .acc_i(acc_i), .frame_start_i(frame_start_i),
   .rdata_o(rdata_o), .cur_addr_o(cur_addr_o), .setup_o(setup_o),
   .soft_reset_o(soft_reset_o));
`default_nettype wire

/* spcr_host.sv */
/* Host model issuing one byte access at a time.
   Assumes each access is started just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module spcr_host (
   // Clock
   input wire logic clk_sys_i,
   // Access towards the register bank
   output spcr_pkg::spcr_access_t acc_o,
   output logic frame_o
);
   initial
   begin
      acc_o = '0;
      frame_o = 1'b0;
   end
   // Idle lines carry the inverse so stale values never look valid.
   // Frame start is raised only when the caller asks for it, so that the
   // bank steps its walk between the bytes of one frame.
   task automatic xfer(input logic w, input logic [13:0] a,
      input logic [7:0] d, input logic f);
      acc_o <= '{w, !w, a, d};
      frame_o <= f;
      @(posedge clk_sys_i);
      acc_o <= '{1'b0, 1'b0, ~a, ~d};
      frame_o <= 1'b0;
   endtask : xfer
endmodule : spcr_host
`default_nettype wire

/* serial_port_config_regs_test.sv */
/* Self-checking bench of the register bank.
   Assumes the host model drives every access. */
`timescale 1ns/1ps
`default_nettype none
module serial_port_config_regs_test;
   logic clk_sys_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic ce_i = 1'b1;
   spcr_pkg::spcr_access_t acc;
   spcr_pkg::spcr_setup_t setup;
   logic frame;
   logic [7:0] rdata;
   logic [13:0] cur;
   logic srst;
   int n_mismatch = 0;
   int checks = 0;
   int cycles = 0;
   always #10 clk_sys_i = ~clk_sys_i;
   spcr_host host (.clk_sys_i(clk_sys_i), .acc_o(acc), .frame_o(frame));
   spcr_regs uut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
      .acc_i(acc), .frame_start_i(frame), .rdata_o(rdata),
      .cur_addr_o(cur), .setup_o(setup), .soft_reset_o(srst));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [13:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      host.xfer(1'b1, a, d, 1'b0);
      @(negedge clk_sys_i);
   endtask : wr
   task automatic rd(input logic [13:0] a, input logic [7:0] e);
      @(posedge clk_sys_i);
      host.xfer(1'b0, a, 8'h00, 1'b0);
      @(negedge clk_sys_i);
      chk(rdata, e);
   endtask : rd
   task automatic t_masks;
      @(negedge clk_sys_i);
      chk(setup, 16'h006e);
      rd(spcr_pkg::OFS_LINK_PRIMARY, spcr_pkg::RST_LINK_PRIMARY);
      wr(14'h0000, 8'h7e);
      rd(14'h0000, 8'h30);
      wr(14'h0001, 8'hff);
      rd(14'h0001, 8'h88);
      chk(setup, 16'h01e6);
      wr(14'h0002, 8'hff);
      rd(14'h0002, 8'h00);
   endtask : t_masks
   task automatic t_step;
      rd(14'h0005, 8'h00);
      chk(cur, 16'h0006);
      wr(14'h0000, 8'h00);
      rd(14'h0000, 8'h10);
      chk(cur, 16'h3fff);
      @(posedge clk_sys_i);
      host.xfer(1'b0, 14'h0001, 8'h00, 1'b1);
      @(negedge clk_sys_i);
      chk(cur, 16'h0001);
      chk(rdata, 16'h0088);
   endtask : t_step
   task automatic t_soft;
      wr(14'h0000, 8'h80);
      chk(srst, 16'h0000);
      wr(14'h0000, 8'h01);
      chk(srst, 16'h0000);
      wr(14'h0000, 8'ha1);
      chk(srst, 16'h0001);
      rd(14'h0000, 8'h30);
      rd(14'h0001, 8'h80);
   endtask : t_soft
   task automatic t_freeze;
      @(posedge clk_sys_i);
      ce_i <= 1'b0;
      wr(14'h0000, 8'h00);
      rd(14'h0000, 8'h80);
      chk(cur, 16'h0002);
      @(posedge clk_sys_i);
      ce_i <= 1'b1;
      rd(14'h0000, 8'h30);
   endtask : t_freeze
   task automatic t_rst;
      @(posedge clk_sys_i);
      arst_n_i <= 1'b0;
      @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      @(negedge clk_sys_i);
      chk(rdata, 16'h0000);
      chk(cur, 16'h0000);
      chk(setup, 16'h006e);
      rd(14'h0000, 8'h10);
   endtask : t_rst
   task automatic conclude;
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude
   // The ceiling is far above the few dozen cycles the scenarios need.
   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 1000)
      begin
         n_mismatch++;
         conclude();
      end
   end
   initial
   begin
      repeat (3) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      t_masks();
      t_step();
      t_soft();
      t_freeze();
      t_rst();
      conclude();
   end
endmodule : serial_port_config_regs_test
`default_nettype wire
